// ===== design/pcf_pkg.sv
/*
  package for the port pin change flag block: register offsets, field layout,
  reset values and interrupt bit positions.
  assumes a plain register port with byte-wide registers at byte offsets.
*/
package pcf_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned PIN_COUNT  = 6;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 4;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_FLAGS     = 4'h0;
  localparam logic [3:0] OFS_RISE_EN   = 4'h1;
  localparam logic [3:0] OFS_FALL_EN   = 4'h2;
  localparam logic [3:0] OFS_PIN_LEVEL = 4'h3;
  localparam logic [3:0] OFS_CTRL      = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT  = 4'h5;
  localparam logic [3:0] OFS_IRQ_MASK  = 4'h6;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned CTRL_GIE_BIT      = 0;
  localparam int unsigned CTRL_SUM_EN_BIT   = 1;
  localparam int unsigned CTRL_SUMMARY_BIT  = 4;
  localparam int unsigned IRQ_SUMMARY_BIT   = 0;
  localparam int unsigned IRQ_WIDTH         = 1;
  localparam int unsigned DBG_PIN_COUNT     = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [5:0] EN_RESET    = 6'h00;
  localparam logic [1:0] CTRL_RESET  = 2'h0;
  localparam logic [0:0] IRQ_RESET   = 1'h0;
  localparam logic [7:0] READ_ZERO   = 8'h00;

endpackage

// ===== design/pcf_port_pin_change_flags.sv
/*
  port pin change flag block: synchronises six port pins, detects enabled
  rising and falling edges, keeps sticky per-pin flags and a summary flag.
  assumes pins are asynchronous to sys_clk and that the register master
  follows the one-cycle strobe protocol with read data one cycle later.
*/
// The address-and-strobe port and the placing of the registers are this design's own decisions.
// Summary of operation
// - set a pin flag on rising edge when its rise enable is one
// - set a pin flag on falling edge when its fall enable is one
// - flags stay set until software clears them; cleared reads zero
// - flag register bits five to zero map to pins five to zero
// - flag bits seven and six read zero and ignore writes
// - debugger enabled blocks change detection on pins one and zero
// - flags set regardless of interrupt enables or global enable
`timescale 1ns/1ps

module pcf_port_pin_change_flags #(
  parameter int unsigned PINS = pcf_pkg::PIN_COUNT
) (
  input  wire logic                            sys_clk,
  input  wire logic                            arst_n,
  input  wire logic [PINS-1:0]                 port_a_pin,
  input  wire logic                            debugger_enable,
  input  wire logic [pcf_pkg::ADDR_WIDTH-1:0]  reg_addr,
  input  wire logic [pcf_pkg::DATA_WIDTH-1:0]  reg_wdata,
  input  wire logic                            reg_write,
  input  wire logic                            reg_read,
  output logic      [pcf_pkg::DATA_WIDTH-1:0]  reg_rdata,
  output logic                                 change_summary_flag,
  output logic                                 irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic [PINS-1:0] prev_pin;
  logic [PINS-1:0] pin_rise_detect_enable;
  logic [PINS-1:0] pin_fall_detect_enable;
  logic [PINS-1:0] port_a_change_flags;
  logic [PINS-1:0] pin_avail;
  logic [PINS-1:0] edge_hit;
  logic            dbg_sync_a;
  logic            dbg_sync_b;
  logic            global_interrupt_enable;
  logic            summary_int_enable;
  logic            irq_status;
  logic            irq_mask;
  logic            summary_now;
  logic            summary_rise;
  logic            summary_prev;
  logic            wr_flags;
  logic            rd_irq;

  assign wr_flags = reg_write && (reg_addr == pcf_pkg::OFS_FLAGS);
  assign rd_irq   = reg_read && (reg_addr == pcf_pkg::OFS_IRQ_STAT);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two-stage sync
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a     <= '0;
      sync_b     <= '0;
      prev_pin   <= '0;
      dbg_sync_a <= 1'b0;
      dbg_sync_b <= 1'b0;
    end else begin
      sync_a     <= port_a_pin;
      sync_b     <= sync_a;
      prev_pin   <= sync_b;
      dbg_sync_a <= debugger_enable;
      dbg_sync_b <= dbg_sync_a;
    end
  end

  // ----------------------------------------
  // edge detection and flags
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      if (gi < pcf_pkg::DBG_PIN_COUNT) begin : g_dbg
        assign pin_avail[gi] = ~dbg_sync_b;
      end else begin : g_free
        assign pin_avail[gi] = 1'b1;
      end
      assign edge_hit[gi] = pin_avail[gi] &&
                            ((pin_rise_detect_enable[gi] && sync_b[gi] && !prev_pin[gi]) ||
                             (pin_fall_detect_enable[gi] && !sync_b[gi] && prev_pin[gi]));

      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          port_a_change_flags[gi] <= pcf_pkg::FLAGS_RESET[gi];
        end else if (edge_hit[gi]) begin
          port_a_change_flags[gi] <= 1'b1;
        end else if (wr_flags) begin
          port_a_change_flags[gi] <= reg_wdata[gi] & port_a_change_flags[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_rise_detect_enable <= pcf_pkg::EN_RESET;
      pin_fall_detect_enable <= pcf_pkg::EN_RESET;
    end else if (reg_write) begin
      if (reg_addr == pcf_pkg::OFS_RISE_EN) begin
        pin_rise_detect_enable <= reg_wdata[PINS-1:0];
      end
      if (reg_addr == pcf_pkg::OFS_FALL_EN) begin
        pin_fall_detect_enable <= reg_wdata[PINS-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      global_interrupt_enable <= pcf_pkg::CTRL_RESET[pcf_pkg::CTRL_GIE_BIT];
      summary_int_enable      <= pcf_pkg::CTRL_RESET[pcf_pkg::CTRL_SUM_EN_BIT];
      irq_mask                <= pcf_pkg::IRQ_RESET[0];
    end else if (reg_write) begin
      if (reg_addr == pcf_pkg::OFS_CTRL) begin
        global_interrupt_enable <= reg_wdata[pcf_pkg::CTRL_GIE_BIT];
        summary_int_enable      <= reg_wdata[pcf_pkg::CTRL_SUM_EN_BIT];
      end
      if (reg_addr == pcf_pkg::OFS_IRQ_MASK) begin
        irq_mask <= reg_wdata[pcf_pkg::IRQ_SUMMARY_BIT];
      end
    end
  end

  // ----------------------------------------
  // summary flag and interrupt
  // ----------------------------------------
  assign summary_now  = |port_a_change_flags;
  assign summary_rise = summary_now && !summary_prev;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      change_summary_flag <= 1'b0;
      summary_prev        <= 1'b0;
    end else begin
      change_summary_flag <= summary_now;
      summary_prev        <= summary_now;
    end
  end

  // sticky status, read clears, set wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= pcf_pkg::IRQ_RESET[0];
    end else if (summary_rise) begin
      irq_status <= 1'b1;
    end else if (rd_irq) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_status && irq_mask && global_interrupt_enable && summary_int_enable;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= pcf_pkg::READ_ZERO;
    end else begin
      reg_rdata <= pcf_pkg::READ_ZERO;
      if (reg_read) begin
        case (reg_addr)
          pcf_pkg::OFS_FLAGS:     reg_rdata <= {2'b00, port_a_change_flags};
          pcf_pkg::OFS_RISE_EN:   reg_rdata <= {2'b00, pin_rise_detect_enable};
          pcf_pkg::OFS_FALL_EN:   reg_rdata <= {2'b00, pin_fall_detect_enable};
          pcf_pkg::OFS_PIN_LEVEL: reg_rdata <= {2'b00, sync_b};
          pcf_pkg::OFS_CTRL:      reg_rdata <= {3'b000, summary_now, 2'b00,
                                                summary_int_enable, global_interrupt_enable};
          pcf_pkg::OFS_IRQ_STAT:  reg_rdata <= {7'h00, irq_status};
          pcf_pkg::OFS_IRQ_MASK:  reg_rdata <= {7'h00, irq_mask};
          default:                reg_rdata <= pcf_pkg::READ_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_rise_sets;
    @(posedge sys_clk) disable iff (!arst_n)
      (pin_rise_detect_enable[2] && sync_b[2] && !prev_pin[2]) |=> port_a_change_flags[2];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise did not set flag");

  property p_fall_sets;
    @(posedge sys_clk) disable iff (!arst_n)
      (pin_fall_detect_enable[3] && !sync_b[3] && prev_pin[3]) |=> port_a_change_flags[3];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall did not set flag");

  property p_sticky;
    @(posedge sys_clk) disable iff (!arst_n)
      (port_a_change_flags[4] && !wr_flags) |=> port_a_change_flags[4];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_read_map;
    @(posedge sys_clk) disable iff (!arst_n)
      (reg_read && reg_addr == pcf_pkg::OFS_FLAGS) |=> reg_rdata[5:0] == $past(port_a_change_flags);
  endproperty
  a_read_map: assert property (p_read_map) else $error("flag read mismatch");

  property p_upper_zero;
    @(posedge sys_clk) disable iff (!arst_n)
      ($past(reg_read) && $past(reg_addr) == pcf_pkg::OFS_FLAGS) |-> reg_rdata[7:6] == 2'b00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper flag bits not zero");

  property p_dbg_block;
    @(posedge sys_clk) disable iff (!arst_n)
      (dbg_sync_b && !port_a_change_flags[0]) |=> !port_a_change_flags[0];
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("debug pin flag set");

  property p_no_gating;
    @(posedge sys_clk) disable iff (!arst_n)
      (edge_hit[5] && !global_interrupt_enable) |=> port_a_change_flags[5];
  endproperty
  a_no_gating: assert property (p_no_gating) else $error("flag gated by enable");

  property p_one_set;
    @(posedge sys_clk) disable iff (!arst_n)
      (!pin_avail[1] || (sync_b[1] == prev_pin[1])) |-> !edge_hit[1];
  endproperty
  a_one_set: assert property (p_one_set) else $error("set without edge");

  property p_summary;
    @(posedge sys_clk) disable iff (!arst_n)
      ##1 change_summary_flag == |$past(port_a_change_flags);
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag wrong");

  c_rise: cover property (@(posedge sys_clk) disable iff (!arst_n) edge_hit[2] ##1 port_a_change_flags[2]);
  c_clear: cover property (@(posedge sys_clk) disable iff (!arst_n) port_a_change_flags[0] ##1 !port_a_change_flags[0]);
  c_irq: cover property (@(posedge sys_clk) disable iff (!arst_n) irq);

endmodule

// ===== tb/pcf_pin_model.sv
/*
  partner model: outside circuitry driving the six port pins.
  assumes the bench calls drive right after a rising edge of sys_clk.
*/
`timescale 1ns/1ps

module pcf_pin_model (
  input  wire logic       sys_clk,
  output logic      [5:0] port_a_pin
);
  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  initial port_a_pin = 6'h00;

  task automatic drive(input logic [5:0] v);
    port_a_pin <= v;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// ===== tb/tb_port_pin_change_flags.sv
/*
  testbench for the port pin change flag block: drives the register port and
  the pin model, checks flags, summary flag and interrupt.
  assumes the design answers reads one cycle after the read strobe.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end

module tb_port_pin_change_flags;
  logic       sys_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [5:0] port_a_pin;
  logic       debugger_enable = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       change_summary_flag;
  logic       irq;
  int         fail_count = 0;
  int         checks_done = 0;
  int         cyc = 0;
  logic [7:0] d;

  always #12.5 sys_clk = ~sys_clk;

  pcf_pin_model pins (.sys_clk(sys_clk), .port_a_pin(port_a_pin));

  pcf_port_pin_change_flags uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .port_a_pin(port_a_pin),
    .debugger_enable(debugger_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .change_summary_flag(change_summary_flag), .irq(irq)
  );

  // ----------------------------------------
  // register port
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_write <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_read <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset;
    rd(pcf_pkg::OFS_FLAGS, d);   `CHK(d, 8'h00)
    rd(pcf_pkg::OFS_RISE_EN, d); `CHK(d, 8'h00)
    rd(pcf_pkg::OFS_FALL_EN, d); `CHK(d, 8'h00)
  endtask

  task automatic s_rise_fall;
    wr(pcf_pkg::OFS_RISE_EN, 8'h3C);
    pins.drive(6'h3F);
    rd(pcf_pkg::OFS_FLAGS, d); `CHK(d, 8'h3C)
    rd(pcf_pkg::OFS_PIN_LEVEL, d); `CHK(d, 8'h3F)
    `CHK(irq, 1'b0)
    wr(pcf_pkg::OFS_FALL_EN, 8'h0B);
    pins.drive(6'h00);
    rd(pcf_pkg::OFS_FLAGS, d); `CHK(d, 8'h3F)
    `CHK(change_summary_flag, 1'b1)
  endtask

  task automatic s_clear;
    wr(pcf_pkg::OFS_FLAGS, 8'hFF);
    rd(pcf_pkg::OFS_FLAGS, d); `CHK(d, 8'h3F)
    wr(pcf_pkg::OFS_FLAGS, 8'h1F);
    rd(pcf_pkg::OFS_FLAGS, d); `CHK(d, 8'h1F)
    wr(pcf_pkg::OFS_FLAGS, 8'h00);
    rd(pcf_pkg::OFS_FLAGS, d); `CHK(d, 8'h00)
    rd(4'hF, d); `CHK(d, 8'h00)
  endtask

  task automatic s_debug;
    debugger_enable <= 1'b1;
    wr(pcf_pkg::OFS_RISE_EN, 8'h3F);
    repeat (4) @(posedge sys_clk);
    pins.drive(6'h3F);
    rd(pcf_pkg::OFS_FLAGS, d); `CHK(d, 8'h3C)
    debugger_enable <= 1'b0;
    wr(pcf_pkg::OFS_FLAGS, 8'h00);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic s_irq;
    wr(pcf_pkg::OFS_CTRL, 8'h03);
    wr(pcf_pkg::OFS_IRQ_MASK, 8'h00);
    pins.drive(6'h00);
    `CHK(irq, 1'b0)
    rd(pcf_pkg::OFS_CTRL, d); `CHK(d, 8'h13)
    wr(pcf_pkg::OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    rd(pcf_pkg::OFS_IRQ_STAT, d); `CHK(d, 8'h01)
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    rd(pcf_pkg::OFS_FLAGS, d); `CHK(d, 8'h0B)
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    s_reset();
    s_rise_fall();
    s_clear();
    s_debug();
    s_irq();
    give_verdict();
  end
endmodule
